// ---- verilog/tbm_monitor_regs.svh ----
// Purpose: Register offsets, field positions, reset values and timing counts of the monitor.
// Assumes: 12-bit APB byte address, one 32-bit word per register.
// Notes:   Counter windows are indexed by word; the index sits in paddr[7:2].
`ifndef TBM_MONITOR_REGS_SVH
`define TBM_MONITOR_REGS_SVH

`define TBM_CTRL          12'h000
`define TBM_CMD           12'h004
`define TBM_STATUS        12'h008
`define TBM_MEM_ADDR      12'h00c
`define TBM_MEM_DATA      12'h010
`define TBM_PROBE_SEL     12'h014
`define TBM_WR_PTR        12'h018
`define TBM_GROUP_PAGE    4'h1
`define TBM_SCALER_PAGE   4'h2
`define TBM_TIMER_PAGE    4'h4

`define TBM_CTRL_MODE_LSB 0
`define TBM_CTRL_PROBE_EN 2
`define TBM_CMD_START     0
`define TBM_CMD_HALT      1
`define TBM_CMD_CLEAR     2
`define TBM_STAT_ACTIVE   0
`define TBM_STAT_FULL     1
`define TBM_STAT_PLAY     2
`define TBM_SEL_A_LSB     0
`define TBM_SEL_B_LSB     8

`define TBM_CTRL_RST      32'h0000_0000
`define TBM_TICK_DIV      16

`endif

// ---- verilog/tbm_pkg.sv ----
// Purpose: Types and Gray-code helpers of the trigger board monitor.
// Assumes: Counters are 32 bits wide.
// Notes:   Constants live in tbm_monitor_regs.svh.
package tbm_pkg;

   typedef enum logic [1:0] {CAP_IDLE, CAP_RUN, CAP_PLAY} tbm_cap_e;
   typedef enum logic [1:0] {MODE_AFTER, MODE_BEFORE, MODE_PLAY, MODE_RSVD} tbm_mode_e;
   typedef logic [31:0] tbm_word_t;

   function automatic tbm_word_t tbm_g2b(input tbm_word_t g);
      tbm_word_t b;
      b[31] = g[31];
      for (int i = 30; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : tbm_g2b

   function automatic tbm_word_t tbm_b2g(input tbm_word_t b);
      return b ^ (b >> 1);
   endfunction : tbm_b2g

   function automatic tbm_word_t tbm_ginc(input tbm_word_t g);
      return tbm_b2g(tbm_g2b(g) + 32'h0000_0001);
   endfunction : tbm_ginc

endpackage : tbm_pkg

// ---- verilog/tbm_mem_if.sv ----
// Purpose: Carrier between the capture control and the capture memory.
// Assumes: One write port and one read port, both on pclk.
// Notes:   Read data is registered inside the memory.
`timescale 1ns/1ps
interface tbm_mem_if #(
   parameter int W  = 16,
   parameter int AW = 20
);
   logic          we;
   logic [AW-1:0] waddr;
   logic [W-1:0]  wdata;
   logic [AW-1:0] raddr;
   logic [W-1:0]  rdata;

   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tbm_mem_if

// ---- verilog/tbm_capture_mem.sv ----
// Purpose: Sample capture memory, 2**AW words.
// Assumes: Simple dual port, read data one cycle after the address.
// Notes:   Array content has no reset, as in any block RAM.
`timescale 1ns/1ps
module tbm_capture_mem #(
   parameter int W  = 16,
   parameter int AW = 20
) (
   // Clock.
   input wire logic pclk,
   // Ports.
   tbm_mem_if.mem   port
);
   import tbm_pkg::*;

   logic [W-1:0] store [2**AW];
   logic [W-1:0] rdata;

   always_ff @(posedge pclk) begin
      if (port.we) begin
         store[port.waddr] <= port.wdata;
      end
      rdata <= store[port.raddr];
   end

   assign port.rdata = rdata;
endmodule : tbm_capture_mem

// ---- verilog/tbm_monitor.sv ----
// Purpose: Monitoring block of a trigger board: Gray scalers, busy timers, capture
//          memory with playback, and two probe outputs, all behind an APB slave.
// Assumes: All inputs synchronous to pclk; pclk is the bunch crossing clock.
// Notes:   Overview of operation and tags follow.
// Overview of operation
// - Every scaler and timer is a 32-bit counter.
// - Counters step in Gray code so that a live read never sees a multi-bit change.
// - A bus read of a counter returns its value converted to plain binary.
// - There is one timer per busy input (24) and one per group busy signal.
// - A timer steps once every 16 clocks, and only while its input is high.
// - The capture memory holds one million words of the sampled signals, one per clock.
// - In sample-after mode a start command begins capture and a full memory ends it.
// - In sample-before mode capture wraps through memory until a halt command stops it.
// - The orbit marker is written into every captured word.
// - Playback mode drives stored words out as repeatable stimulus.
// - Two selectable probe outputs A and B drive the shared backplane bus.
// - A group busy is the OR of the busy inputs of its member sub-detectors.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "tbm_monitor_regs.svh"
module tbm_monitor
   import tbm_pkg::*;
#(
   parameter int NB = 24,
   parameter int NG = 7,
   parameter int NS = 8,
   parameter int SW = 15,
   parameter int AW = 20
) (
   // Clock and reset.
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave.
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Monitored signals.
   input  wire logic [NB-1:0] busy_in,
   input  wire logic [NS-1:0] scaler_evt,
   input  wire logic [SW-1:0] sample_in,
   input  wire logic          orbit,
   // Probe pair, low enable drives the backplane.
   output logic               probe_a_o,
   output logic               probe_a_oe_n,
   output logic               probe_b_o,
   output logic               probe_b_oe_n,
   // Playback stimulus.
   output logic [SW:0]        play_out
);
   localparam int NT = NB + NG;
   localparam int W  = SW + 1;

   typedef struct packed {
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
      logic                     rd_pend;
      tbm_mode_e                mode;
      logic                     probe_en;
      logic [5:0]               sel_a;
      logic [5:0]               sel_b;
      logic [AW-1:0]            mem_addr;
      logic [AW-1:0]            wptr;
      logic [AW-1:0]            pb_addr;
      logic                     full;
      tbm_cap_e                 cap;
      logic [3:0]               presc;
      logic [NG-1:0][NB-1:0]    gmask;
      logic [NS-1:0][31:0]      scal;
      logic [NT-1:0][31:0]      tmr;
      logic                     probe_a;
      logic                     probe_b;
      logic                     probe_a_oe_n;
      logic                     probe_b_oe_n;
      logic [SW:0]              play_out;
   } tbm_state_s;

   tbm_state_s    s;
   tbm_state_s    next_s;
   logic          tick;
   logic [NG-1:0] grp;
   logic [NT-1:0] tmr_in;
   logic [63:0]   src;
   logic          setup;
   logic          wr;
   logic          hit;
   logic [31:0]   rd_val;
   logic [5:0]    idx;
   logic          cmd_start;
   logic          cmd_halt;
   logic          cmd_clear;

   tbm_mem_if #(.W(W), .AW(AW)) mif ();

   tbm_capture_mem #(.W(W), .AW(AW)) u_mem (
      .pclk (pclk),
      .port (mif.mem)
   );

   // Capture writes at the write pointer; playback owns the read port while it runs.
   assign mif.we    = (s.cap == CAP_RUN);
   assign mif.waddr = s.wptr;
   assign mif.wdata = {orbit, sample_in};
   assign mif.raddr = (s.cap == CAP_PLAY) ? s.pb_addr : s.mem_addr;

   always_comb begin
      next_s = s;
      idx    = paddr[7:2];
      setup  = psel & ~penable;
      wr     = psel & penable & pwrite & s.pready;
      // The prescaler never stops, so every timer sees the same tick phase.
      tick   = (s.presc == 4'(`TBM_TICK_DIV - 1));
      next_s.presc = s.presc + 4'h1;
      for (int g = 0; g < NG; g++) begin
         grp[g] = |(busy_in & s.gmask[g]);
      end
      tmr_in = {grp, busy_in};
      src    = 64'({scaler_evt, sample_in, (s.cap != CAP_IDLE), tick, orbit, grp, busy_in});

      // Register read decode.
      hit    = 1'b1;
      rd_val = 32'h0000_0000;
      if (paddr == `TBM_CTRL) begin
         rd_val = {29'h0, s.probe_en, s.mode};
      end else if (paddr == `TBM_CMD) begin
         rd_val = 32'h0000_0000;
      end else if (paddr == `TBM_STATUS) begin
         rd_val = {29'h0, (s.cap == CAP_PLAY), s.full, (s.cap != CAP_IDLE)};
      end else if (paddr == `TBM_MEM_ADDR) begin
         rd_val = 32'(s.mem_addr);
      end else if (paddr == `TBM_MEM_DATA) begin
         rd_val = 32'(mif.rdata);
      end else if (paddr == `TBM_PROBE_SEL) begin
         rd_val = {18'h0, s.sel_b, 2'b00, s.sel_a};
      end else if (paddr == `TBM_WR_PTR) begin
         rd_val = 32'(s.wptr);
      end else if (paddr[11:8] == `TBM_GROUP_PAGE && 32'(idx) < NG) begin
         rd_val = 32'(s.gmask[idx]);
      end else if (paddr[11:8] == `TBM_SCALER_PAGE && 32'(idx) < NS) begin
         rd_val = tbm_g2b(s.scal[idx]);
      end else if (paddr[11:8] == `TBM_TIMER_PAGE && 32'(idx) < NT) begin
         rd_val = tbm_g2b(s.tmr[idx]);
      end else begin
         hit = 1'b0;
      end

      // APB handshake: answer at the first access cycle, memory data one cycle later.
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      next_s.rd_pend = 1'b0;
      if (setup) begin
         if (!pwrite && paddr == `TBM_MEM_DATA) begin
            next_s.rd_pend = 1'b1;
         end else begin
            next_s.pready  = 1'b1;
            next_s.pslverr = ~hit;
            if (!pwrite) begin
               next_s.prdata = rd_val;
            end
         end
      end
      if (s.rd_pend) begin
         next_s.pready = 1'b1;
         next_s.prdata = rd_val;
      end

      // Register writes take effect at the completing access edge.
      cmd_start = 1'b0;
      cmd_halt  = 1'b0;
      cmd_clear = 1'b0;
      if (wr && hit) begin
         if (paddr == `TBM_CTRL) begin
            next_s.mode     = tbm_mode_e'(pwdata[`TBM_CTRL_MODE_LSB +: 2]);
            next_s.probe_en = pwdata[`TBM_CTRL_PROBE_EN];
         end else if (paddr == `TBM_CMD) begin
            cmd_start = pwdata[`TBM_CMD_START];
            cmd_halt  = pwdata[`TBM_CMD_HALT];
            cmd_clear = pwdata[`TBM_CMD_CLEAR];
         end else if (paddr == `TBM_MEM_ADDR) begin
            next_s.mem_addr = pwdata[AW-1:0];
         end else if (paddr == `TBM_PROBE_SEL) begin
            next_s.sel_a = pwdata[`TBM_SEL_A_LSB +: 6];
            next_s.sel_b = pwdata[`TBM_SEL_B_LSB +: 6];
         end else if (paddr[11:8] == `TBM_GROUP_PAGE) begin
            next_s.gmask[idx] = pwdata[NB-1:0];
         end
      end

      // Event scalers and busy timers, all 32-bit Gray counters.
      for (int i = 0; i < NS; i++) begin
         if (cmd_clear) begin
            next_s.scal[i] = 32'h0000_0000;
         end else if (scaler_evt[i]) begin
            next_s.scal[i] = tbm_ginc(s.scal[i]);
         end
      end
      for (int i = 0; i < NT; i++) begin
         if (cmd_clear) begin
            next_s.tmr[i] = 32'h0000_0000;
         end else if (tick && tmr_in[i]) begin
            next_s.tmr[i] = tbm_ginc(s.tmr[i]);
         end
      end

      // Capture and playback sequencing.
      case (s.cap)
         CAP_IDLE: begin
            if (cmd_start) begin
               if (s.mode == MODE_PLAY) begin
                  next_s.cap     = CAP_PLAY;
                  next_s.pb_addr = '0;
               end else if (s.mode != MODE_RSVD) begin
                  next_s.cap  = CAP_RUN;
                  next_s.wptr = '0;
                  next_s.full = 1'b0;
               end
            end
         end
         CAP_RUN: begin
            next_s.wptr = s.wptr + 1'b1;
            if (s.wptr == '1) begin
               next_s.full = 1'b1;
               // Sample-after ends on the last word; sample-before wraps over the oldest.
               if (s.mode != MODE_BEFORE) begin
                  next_s.cap = CAP_IDLE;
               end
            end
            if (cmd_halt) begin
               next_s.cap = CAP_IDLE;
            end
         end
         CAP_PLAY: begin
            next_s.pb_addr = s.pb_addr + 1'b1;
            if (cmd_halt) begin
               next_s.cap = CAP_IDLE;
            end
         end
         default: begin
            next_s.cap = CAP_IDLE;
         end
      endcase
      next_s.play_out = (s.cap == CAP_PLAY) ? mif.rdata : '0;

      // Probe pair onto the shared bus, released when disabled.
      next_s.probe_a      = src[s.sel_a];
      next_s.probe_b      = src[s.sel_b];
      next_s.probe_a_oe_n = ~s.probe_en;
      next_s.probe_b_oe_n = ~s.probe_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign prdata       = s.prdata;
   assign pready       = s.pready;
   assign pslverr      = s.pslverr;
   assign probe_a_o    = s.probe_a;
   assign probe_a_oe_n = s.probe_a_oe_n;
   assign probe_b_o    = s.probe_b;
   assign probe_b_oe_n = s.probe_b_oe_n;
   assign play_out     = s.play_out;

   a_scaler_gray_step : assert property (@(posedge pclk) disable iff (!presetn)
      ($past(presetn) && s.scal[0] != $past(s.scal[0]) && !$past(cmd_clear))
      |-> $countones(s.scal[0] ^ $past(s.scal[0])) == 1)
      else $error("scaler 0 changed more than one bit");

   a_scaler_read_bin : assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == {`TBM_SCALER_PAGE, 8'h00})
      |=> prdata == tbm_g2b($past(s.scal[0])) && pready)
      else $error("scaler read not converted to binary");

   a_tick_period : assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> !tick [*8] ##1 !tick [*7] ##1 tick)
      else $error("prescaler tick not every 16 clocks");

   a_timer_gated : assert property (@(posedge pclk) disable iff (!presetn)
      (s.tmr[0] != $past(s.tmr[0]) && !$past(cmd_clear))
      |-> $past(tick) && $past(busy_in[0]))
      else $error("busy timer 0 advanced without tick and busy");

   a_group_timer_or : assert property (@(posedge pclk) disable iff (!presetn)
      (tick && |(busy_in & s.gmask[0]) && !cmd_clear)
      |=> s.tmr[NB] == tbm_ginc($past(s.tmr[NB])))
      else $error("group 0 timer missed a member busy");

   a_after_stop : assert property (@(posedge pclk) disable iff (!presetn)
      (s.cap == CAP_RUN && s.mode == MODE_AFTER && s.wptr == '1)
      |=> s.cap == CAP_IDLE && s.full)
      else $error("sample-after capture did not stop when full");

   a_before_halt : assert property (@(posedge pclk) disable iff (!presetn)
      (s.cap == CAP_RUN && cmd_halt) |=> s.cap == CAP_IDLE ##1 !mif.we)
      else $error("sample-before capture ignored halt");

   a_orbit_record : assert property (@(posedge pclk) disable iff (!presetn)
      mif.we |=> u_mem.store[$past(mif.waddr)][SW] == $past(orbit))
      else $error("orbit marker not in captured word");

   a_play_drive : assert property (@(posedge pclk) disable iff (!presetn)
      (s.cap == CAP_PLAY) |=> play_out == $past(mif.rdata))
      else $error("playback output not from memory");

   a_probe_enable : assert property (@(posedge pclk) disable iff (!presetn)
      (s.probe_en && $past(s.probe_en)) |-> !probe_a_oe_n && !probe_b_oe_n)
      else $error("probe pair not driving while enabled");

   a_active_flag : assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `TBM_STATUS)
      |=> prdata[`TBM_STAT_ACTIVE] == ($past(s.cap) != CAP_IDLE))
      else $error("status active flag wrong");

   a_mem_read_wait : assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `TBM_MEM_DATA)
      |=> !pready ##1 (pready && prdata == 32'($past(mif.rdata))))
      else $error("memory read not answered after one wait state");

   a_play_idle_zero : assert property (@(posedge pclk) disable iff (!presetn)
      (s.cap != CAP_PLAY) |=> play_out == '0)
      else $error("playback output not quiet outside playback");

   a_probe_source : assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn)
      |-> probe_a_o == $past(src[s.sel_a]) && probe_b_o == $past(src[s.sel_b]))
      else $error("probe outputs not from selected sources");

   a_after_step : assert property (@(posedge pclk) disable iff (!presetn)
      (s.cap == CAP_RUN && s.mode == MODE_AFTER && !cmd_halt && s.wptr != '1)
      |=> s.cap == CAP_RUN && s.wptr == $past(s.wptr) + 1'b1)
      else $error("capture did not take one word per clock");

   a_before_wrap : assert property (@(posedge pclk) disable iff (!presetn)
      (s.cap == CAP_RUN && s.mode == MODE_BEFORE && !cmd_halt) |=> s.cap == CAP_RUN)
      else $error("sample-before capture stopped without halt");

   a_group_idle_hold : assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !(|(busy_in & s.gmask[0])) && !cmd_clear)
      |=> s.tmr[NB] == $past(s.tmr[NB]))
      else $error("group 0 timer advanced with no member busy");

endmodule : tbm_monitor

// ---- verif/tbm_apb_host.sv ----
// Purpose: APB master standing in for the control processor of the monitor.
// Assumes: One transfer at a time; signals change just after pclk rises.
// Notes:   The wait for pready is bounded; running out of it is reported as a timeout.
`timescale 1ns/1ps
module tbm_apb_host (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB master side.
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
   end

   // The request is held until pready is seen high or 50 wait cycles pass, which ends it as a timeout.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output bit to);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      q       = prdata;
      e       = pslverr;
      to      = (n >= 50);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : tbm_apb_host

// ---- verif/tb.sv ----
// Purpose: Self-checking bench of the monitor: scalers, timers, capture, playback, probes.
// Assumes: Capture memory shortened to 64 words through AW.
// Notes:   Sample words count up by one a clock, orbit follows bit 0 of the sample.
`timescale 1ns/1ps
`include "tbm_monitor_regs.svh"
module tb;
   import tbm_pkg::*;
   localparam int AW = 6;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, z, w0, w1;
   logic        e;
   logic [23:0] busy_in = 24'h00_0000;
   logic [7:0]  scaler_evt = 8'h00;
   logic [14:0] sample_in = 15'h0000;
   logic        orbit = 1'b0;
   logic        run_smp = 1'b0;
   logic        probe_pat = 1'b0;
   logic        pa, pa_n, pb, pb_n, hit;
   logic [15:0] play_out;
   int          miscompares = 0;
   int          samples_checked = 0;

   always #2.5 pclk = ~pclk;

   always @(posedge pclk) begin
      if (run_smp) begin
         sample_in <= sample_in + 15'h0001;
         orbit     <= ~sample_in[0];
      end else begin
         // Fixed pattern for the probe test: orbit and sample bit 0 always differ.
         sample_in <= {14'h0000, probe_pat};
         orbit     <= ~probe_pat;
      end
   end

   tbm_apb_host i_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   tbm_monitor #(.AW(AW)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busy_in(busy_in), .scaler_evt(scaler_evt),
      .sample_in(sample_in), .orbit(orbit), .probe_a_o(pa), .probe_a_oe_n(pa_n),
      .probe_b_o(pb), .probe_b_oe_n(pb_n), .play_out(play_out));

   task automatic complete_run();
      $display("mismatches %0d, comparisons %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask : chk

   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      bit to;
      i_host.xfer(w, a, d, q, e, to);
      if (to) begin
         $display("wrong value pready expected 1 seen 0");
         miscompares++;
         complete_run();
      end
   endtask : acc

   task automatic expect_rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0000_0000);
      chk(nm, exp, q);
   endtask : expect_rd

   task automatic rd_mem(input int idx, output logic [31:0] m);
      acc(1'b1, `TBM_MEM_ADDR, 32'(idx));
      acc(1'b0, `TBM_MEM_DATA, 32'h0000_0000);
      m = q;
   endtask : rd_mem

   // Polls until capture reports inactive; a flag still set after 100 polls counts as a miscompare.
   task automatic wait_idle();
      int n;
      n = 0;
      acc(1'b0, `TBM_STATUS, 32'h0000_0000);
      while (q[`TBM_STAT_ACTIVE] !== 1'b0 && n < 100) begin
         n++;
         acc(1'b0, `TBM_STATUS, 32'h0000_0000);
      end
      chk("capture stop", 32'h0, 32'(n >= 100));
   endtask : wait_idle

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      expect_rd("ctrl", `TBM_CTRL, `TBM_CTRL_RST);
      expect_rd("status", `TBM_STATUS, 32'h0000_0000);
      acc(1'b0, 12'h0fc, 32'h0000_0000);
      chk("unmapped error", 32'h1, 32'(e));
      // Each scaler sees a different burst length so crossed wiring shows up.
      acc(1'b1, `TBM_CMD, 32'h1 << `TBM_CMD_CLEAR);
      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         scaler_evt <= 8'h01 << i;
         repeat (i + 3) @(posedge pclk);
         scaler_evt <= 8'h00;
      end
      for (int i = 0; i < 8; i++)
         expect_rd("scaler", {`TBM_SCALER_PAGE, 8'(i * 4)}, 32'(i + 3));
      acc(1'b1, {`TBM_GROUP_PAGE, 8'h00}, 32'h0000_0020);
      acc(1'b1, {`TBM_GROUP_PAGE, 8'h04}, 32'h0000_0040);
      acc(1'b1, `TBM_CMD, 32'h1 << `TBM_CMD_CLEAR);
      // 160 busy clocks hold exactly ten prescaler ticks whatever their phase.
      @(posedge pclk);
      busy_in <= 24'h00_0021;
      repeat (160) @(posedge pclk);
      busy_in <= 24'h00_0000;
      expect_rd("timer 0", {`TBM_TIMER_PAGE, 8'h00}, 32'd10);
      expect_rd("timer 5", {`TBM_TIMER_PAGE, 8'h14}, 32'd10);
      expect_rd("timer 6", {`TBM_TIMER_PAGE, 8'h18}, 32'd0);
      expect_rd("group 0", {`TBM_TIMER_PAGE, 8'h60}, 32'd10);
      expect_rd("group 1", {`TBM_TIMER_PAGE, 8'h64}, 32'd0);
      run_smp <= 1'b1;
      acc(1'b1, `TBM_CTRL, 32'h0000_0000);
      acc(1'b1, `TBM_CMD, 32'h1 << `TBM_CMD_START);
      acc(1'b0, `TBM_STATUS, 32'h0000_0000);
      chk("active", 32'h1, 32'(q[`TBM_STAT_ACTIVE]));
      wait_idle();
      expect_rd("after full", `TBM_STATUS, 32'h0000_0002);
      rd_mem(0, w0);
      rd_mem(1, w1);
      chk("next word", 32'(w0[14:0] + 15'h0001), 32'(w1[14:0]));
      chk("orbit bit", 32'(w1[0]), 32'(w1[15]));
      rd_mem(63, w1);
      chk("last word", 32'(w0[14:0] + 15'd63), 32'(w1[14:0]));
      acc(1'b1, `TBM_CTRL, 32'h0000_0001);
      acc(1'b1, `TBM_CMD, 32'h1 << `TBM_CMD_START);
      repeat (100) @(posedge pclk);
      expect_rd("before run", `TBM_STATUS, 32'h0000_0003);
      acc(1'b1, `TBM_CMD, 32'h1 << `TBM_CMD_HALT);
      wait_idle();
      acc(1'b0, `TBM_WR_PTR, 32'h0000_0000);
      w0 = q;
      rd_mem(int'(w0), z);
      rd_mem(int'((w0 + 32'h3f) & 32'h3f), w1);
      chk("window span", 32'd63, 32'(w1[14:0] - z[14:0]));
      rd_mem(0, z);
      acc(1'b1, `TBM_CTRL, 32'h0000_0002);
      acc(1'b1, `TBM_CMD, 32'h1 << `TBM_CMD_START);
      acc(1'b0, `TBM_STATUS, 32'h0000_0000);
      chk("playing", 32'h1, 32'(q[`TBM_STAT_PLAY]));
      hit = 1'b0;
      for (int n = 0; n < 200; n++) begin
         @(posedge pclk);
         if (play_out === z[15:0]) hit = 1'b1;
      end
      chk("playback word", 32'h1, 32'(hit));
      acc(1'b1, `TBM_CMD, 32'h1 << `TBM_CMD_HALT);
      run_smp <= 1'b0;
      acc(1'b1, `TBM_PROBE_SEL, 32'h0000_221f);
      acc(1'b1, `TBM_CTRL, 32'h0000_0004);
      @(posedge pclk);
      probe_pat <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("probe pair", 32'h2, 32'({pa, pb, pa_n, pb_n} >> 2));
      chk("probe drive", 32'h0, 32'({pa_n, pb_n}));
      probe_pat <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("probe swap", 32'h1, 32'({pa, pb}));
      acc(1'b1, `TBM_CTRL, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      chk("probe release", 32'h3, 32'({pa_n, pb_n}));
      complete_run();
   end
endmodule : tb
